// File: core/cbrf_pkg.sv
// Constants and types shared by the banked CPU register file.
// Assumes one core clock and a synchronous active-low reset.
`default_nettype none

package cbrf_pkg;

  localparam int unsigned WORD_W    = 16;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned IP_W      = 20;
  localparam int unsigned NUM_REGS  = 7;
  localparam int unsigned NUM_BANKS = 2;
  localparam int unsigned BUS_AW    = 4;
  localparam int unsigned BUS_DW    = 32;
  localparam int unsigned SEL_W     = 3;
  localparam int unsigned STEP_W    = 3;

  // Index of each banked register in a bank
  localparam logic [2:0] IDX_DATA0 = 3'h0;
  localparam logic [2:0] IDX_DATA1 = 3'h1;
  localparam logic [2:0] IDX_DATA2 = 3'h2;
  localparam logic [2:0] IDX_DATA3 = 3'h3;
  localparam logic [2:0] IDX_ADDR0 = 3'h4;
  localparam logic [2:0] IDX_ADDR1 = 3'h5;
  localparam logic [2:0] IDX_FB    = 3'h6;

  // Software port offsets
  localparam logic [3:0] OFS_DATA0  = 4'h0;
  localparam logic [3:0] OFS_FB     = 4'h6;
  localparam logic [3:0] OFS_IP     = 4'h7;
  localparam logic [3:0] OFS_FLAG   = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'h9;

  // Field positions
  localparam int unsigned FLAG_BANK_BIT    = 4;
  localparam int unsigned STAT_BANK_BIT    = 0;
  localparam int unsigned STAT_REFUSED_BIT = 1;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [19:0] RST_IP   = 20'h00000;
  localparam logic        RST_BANK = 1'b0;

  typedef enum logic [1:0] {
    CBRF_SZ_LO,
    CBRF_SZ_HI,
    CBRF_SZ_WORD,
    CBRF_SZ_PAIR
  } cbrf_size_t;

endpackage

`default_nettype wire

// File: core/cbrf_bank_store.sv
// Two-bank storage of the seven banked registers, byte-writable.
// Assumes the caller merges all write sources into one enable set.
`timescale 1ns/1ns
`default_nettype none

module cbrf_bank_store (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             bank,
  input  wire logic [6:0][1:0]  wr_be,
  input  wire logic [6:0][15:0] wr_val,
  output logic      [6:0][15:0] act_regs
);

  logic [1:0][6:0][15:0] mem_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int b = 0; b < cbrf_pkg::NUM_BANKS; b++) begin
        for (int k = 0; k < cbrf_pkg::NUM_REGS; k++) begin
          mem_q[b][k] <= cbrf_pkg::RST_WORD;
        end
      end
    end else begin
      for (int k = 0; k < cbrf_pkg::NUM_REGS; k++) begin
        for (int h = 0; h < 2; h++) begin
          // Only the selected copy is touched
          if (wr_be[k][h]) begin
            mem_q[bank][k][h*8 +: 8] <= wr_val[k][h*8 +: 8];
          end
        end
      end
    end
  end

  assign act_regs = mem_q[bank];

  bank0_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    bank |=> $stable(mem_q[0]))
    else $error("inactive bank 0 changed");

  bank1_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    !bank |=> $stable(mem_q[1]))
    else $error("inactive bank 1 changed");

endmodule

`default_nettype wire

// File: core/cbrf_regfile.sv
// Banked CPU register file: datapath ports, program counter, software port.
// Assumes a datapath on the same clock and a one-cycle strobe software master.
//
// Contract
// - Eight registers exist, seven of them (four data, two address, frame base) in two banks.
// - Each data register is a 16-bit word usable as source and destination.
// - The first two data registers are also readable and writable as separate bytes.
// - Data registers 2:0 and 3:1 pair into 32-bit values, the higher index on top.
// - Address registers are 16-bit general registers and feed indirect and relative addressing.
// - Address registers 1:0 pair into a 32-bit value with register 1 on top.
// - The 16-bit frame base register feeds frame-relative addressing.
// - The 20-bit instruction pointer holds the next instruction address.
// - Bit 4 of the flag word picks the bank, zero for bank 0 and one for bank 1.
`timescale 1ns/1ns
`default_nettype none

module cbrf_regfile (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Software port
  input  wire logic [3:0]           sw_addr,
  input  wire logic [31:0]          sw_wdata,
  input  wire logic                 sw_we,
  input  wire logic                 sw_re,
  output logic      [31:0]          sw_rdata,
  // Datapath read port A
  input  wire logic [2:0]           dpa_sel,
  input  wire cbrf_pkg::cbrf_size_t dpa_size,
  output logic      [31:0]          dpa_data,
  // Datapath read port B
  input  wire logic [2:0]           dpb_sel,
  input  wire cbrf_pkg::cbrf_size_t dpb_size,
  output logic      [31:0]          dpb_data,
  // Datapath write port
  input  wire logic                 dpw_en,
  input  wire logic [2:0]           dpw_sel,
  input  wire cbrf_pkg::cbrf_size_t dpw_size,
  input  wire logic [31:0]          dpw_data,
  output logic                      dpw_refused,
  // Flag word bank select
  input  wire logic                 flag_we,
  input  wire logic [15:0]          flag_wdata,
  output logic                      active_bank,
  // Instruction pointer
  input  wire logic                 ip_we,
  input  wire logic [19:0]          ip_wdata,
  input  wire logic                 ip_adv,
  input  wire logic [2:0]           ip_step,
  output logic      [19:0]          instruction_pointer,
  // Address bases
  output logic      [15:0]          addr_base_0,
  output logic      [15:0]          addr_base_1,
  output logic      [15:0]          frame_base
);

  // Upper member of a pair; bit 3 marks a legal pair base
  function automatic logic [3:0] pair_upper(input logic [2:0] sel);
    logic [3:0] r;
    r = 4'h0;
    case (sel)
      cbrf_pkg::IDX_DATA0: r = {1'b1, cbrf_pkg::IDX_DATA2};
      cbrf_pkg::IDX_DATA1: r = {1'b1, cbrf_pkg::IDX_DATA3};
      cbrf_pkg::IDX_ADDR0: r = {1'b1, cbrf_pkg::IDX_ADDR1};
      default:             r = 4'h0;
    endcase
    return r;
  endfunction

  function automatic logic byte_ok(input logic [2:0] sel);
    return (sel == cbrf_pkg::IDX_DATA0) || (sel == cbrf_pkg::IDX_DATA1);
  endfunction

  // Shared read formatting for both datapath ports and software
  function automatic logic [31:0] fmt_read(
    input logic [6:0][15:0]     r,
    input logic [2:0]           sel,
    input cbrf_pkg::cbrf_size_t sz
  );
    logic [31:0] v;
    logic [3:0]  up;
    v  = 32'h0000_0000;
    up = pair_upper(sel);
    case (sz)
      cbrf_pkg::CBRF_SZ_LO: begin
        if (byte_ok(sel)) begin
          v = {24'h00_0000, r[sel][7:0]};
        end
      end
      cbrf_pkg::CBRF_SZ_HI: begin
        if (byte_ok(sel)) begin
          v = {24'h00_0000, r[sel][15:8]};
        end
      end
      cbrf_pkg::CBRF_SZ_WORD: begin
        if (sel != 3'h7) begin
          v = {16'h0000, r[sel]};
        end
      end
      cbrf_pkg::CBRF_SZ_PAIR: begin
        if (up[3]) begin
          v = {r[up[2:0]], r[sel]};
        end
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  logic [6:0][15:0] act;
  logic [6:0][1:0]  wr_be;
  logic [6:0][15:0] wr_val;
  logic             bank_q;
  logic             bank_d;
  logic [19:0]      ip_q;
  logic [19:0]      ip_d;
  logic             refused_q;
  logic [31:0]      sw_rdata_q;
  logic [31:0]      dpa_q;
  logic [31:0]      dpb_q;
  logic             dp_valid;
  logic [3:0]       dp_up;
  logic             sw_reg_we;
  logic             sw_ip_we;
  logic             sw_flag_we;
  logic             sw_stat_re;
  logic             bank_wr;

  assign sw_reg_we  = sw_we && (sw_addr <= cbrf_pkg::OFS_FB);
  assign sw_ip_we   = sw_we && (sw_addr == cbrf_pkg::OFS_IP);
  assign sw_flag_we = sw_we && (sw_addr == cbrf_pkg::OFS_FLAG);
  assign sw_stat_re = sw_re && (sw_addr == cbrf_pkg::OFS_STATUS);
  assign bank_wr    = flag_we || sw_flag_we;

  // Legality of the datapath write
  always_comb begin
    dp_up    = pair_upper(dpw_sel);
    dp_valid = 1'b0;
    case (dpw_size)
      cbrf_pkg::CBRF_SZ_LO:   dp_valid = byte_ok(dpw_sel);
      cbrf_pkg::CBRF_SZ_HI:   dp_valid = byte_ok(dpw_sel);
      cbrf_pkg::CBRF_SZ_WORD: dp_valid = (dpw_sel != 3'h7);
      cbrf_pkg::CBRF_SZ_PAIR: dp_valid = dp_up[3];
      default:                dp_valid = 1'b0;
    endcase
  end

  assign dpw_refused = dpw_en && !dp_valid;

  // Merge of write sources; the datapath owns a register it writes,
  // so a software write to it that cycle is dropped whole
  always_comb begin
    wr_be  = '0;
    wr_val = '0;
    for (int k = 0; k < cbrf_pkg::NUM_REGS; k++) begin
      if (sw_reg_we && (sw_addr[2:0] == k[2:0])) begin
        wr_be[k]  = 2'h3;
        wr_val[k] = sw_wdata[15:0];
      end
    end
    if (dpw_en && dp_valid) begin
      case (dpw_size)
        cbrf_pkg::CBRF_SZ_LO: begin
          wr_be[dpw_sel]  = 2'h1;
          wr_val[dpw_sel] = {dpw_data[7:0], dpw_data[7:0]};
        end
        cbrf_pkg::CBRF_SZ_HI: begin
          wr_be[dpw_sel]  = 2'h2;
          wr_val[dpw_sel] = {dpw_data[7:0], dpw_data[7:0]};
        end
        cbrf_pkg::CBRF_SZ_WORD: begin
          wr_be[dpw_sel]  = 2'h3;
          wr_val[dpw_sel] = dpw_data[15:0];
        end
        cbrf_pkg::CBRF_SZ_PAIR: begin
          wr_be[dpw_sel]      = 2'h3;
          wr_val[dpw_sel]     = dpw_data[15:0];
          wr_be[dp_up[2:0]]   = 2'h3;
          wr_val[dp_up[2:0]]  = dpw_data[31:16];
        end
        default: wr_be = '0;
      endcase
    end
  end

  cbrf_bank_store u_store (
    .clk      (clk),
    .rst_b    (rst_b),
    .bank     (bank_q),
    .wr_be    (wr_be),
    .wr_val   (wr_val),
    .act_regs (act)
  );

  // Bank select; datapath flag write beats software
  always_comb begin
    bank_d = bank_q;
    if (flag_we) begin
      bank_d = flag_wdata[cbrf_pkg::FLAG_BANK_BIT];
    end else if (sw_flag_we) begin
      bank_d = sw_wdata[cbrf_pkg::FLAG_BANK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bank_q <= cbrf_pkg::RST_BANK;
    end else begin
      bank_q <= bank_d;
    end
  end

  // Instruction pointer wraps inside the 1 MiB space
  always_comb begin
    ip_d = ip_q;
    if (ip_we) begin
      ip_d = ip_wdata;
    end else if (sw_ip_we) begin
      ip_d = sw_wdata[19:0];
    end else if (ip_adv) begin
      ip_d = ip_q + {17'h0_0000, ip_step};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ip_q <= cbrf_pkg::RST_IP;
    end else begin
      ip_q <= ip_d;
    end
  end

  // Sticky refusal; a new refusal wins over the clear-on-read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      refused_q <= 1'b0;
    end else if (dpw_refused) begin
      refused_q <= 1'b1;
    end else if (sw_stat_re) begin
      refused_q <= 1'b0;
    end
  end

  // Reads see contents before this cycle's writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dpa_q <= 32'h0000_0000;
      dpb_q <= 32'h0000_0000;
    end else begin
      dpa_q <= fmt_read(act, dpa_sel, dpa_size);
      dpb_q <= fmt_read(act, dpb_sel, dpb_size);
    end
  end

  // Software read data stands one cycle only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sw_rdata_q <= 32'h0000_0000;
    end else if (sw_re) begin
      if (sw_addr <= cbrf_pkg::OFS_FB) begin
        sw_rdata_q <= fmt_read(act, sw_addr[2:0], cbrf_pkg::CBRF_SZ_WORD);
      end else if (sw_addr == cbrf_pkg::OFS_IP) begin
        sw_rdata_q <= {12'h000, ip_q};
      end else if (sw_addr == cbrf_pkg::OFS_FLAG) begin
        sw_rdata_q <= 32'(bank_q) << cbrf_pkg::FLAG_BANK_BIT;
      end else if (sw_addr == cbrf_pkg::OFS_STATUS) begin
        sw_rdata_q <= {30'h0000_0000, refused_q, bank_q};
      end else begin
        sw_rdata_q <= 32'h0000_0000;
      end
    end else begin
      sw_rdata_q <= 32'h0000_0000;
    end
  end

  assign sw_rdata            = sw_rdata_q;
  assign dpa_data            = dpa_q;
  assign dpb_data            = dpb_q;
  assign active_bank         = bank_q;
  assign instruction_pointer = ip_q;
  // Combinational from the active bank so address math sees writes at once
  assign addr_base_0         = act[cbrf_pkg::IDX_ADDR0];
  assign addr_base_1         = act[cbrf_pkg::IDX_ADDR1];
  assign frame_base          = act[cbrf_pkg::IDX_FB];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  byte_half_keep_a: assert property (
    dpw_en && (dpw_size == cbrf_pkg::CBRF_SZ_LO) && byte_ok(dpw_sel) && !bank_wr
    |=> act[$past(dpw_sel)] == {$past(act[dpw_sel][15:8]), $past(dpw_data[7:0])})
    else $error("byte write disturbed other half");

  data_pair_a: assert property (
    dpw_en && (dpw_size == cbrf_pkg::CBRF_SZ_PAIR)
    && (dpw_sel == cbrf_pkg::IDX_DATA1) && !bank_wr
    |=> {act[3], act[1]} == $past(dpw_data))
    else $error("data pair write wrong");

  addr_pair_a: assert property (
    dpw_en && (dpw_size == cbrf_pkg::CBRF_SZ_PAIR)
    && (dpw_sel == cbrf_pkg::IDX_ADDR0) && !bank_wr
    |=> {addr_base_1, addr_base_0} == $past(dpw_data))
    else $error("address pair write wrong");

  frame_base_a: assert property (
    dpw_en && (dpw_size == cbrf_pkg::CBRF_SZ_WORD)
    && (dpw_sel == cbrf_pkg::IDX_FB) && !bank_wr
    |=> frame_base == $past(dpw_data[15:0]))
    else $error("frame base not written");

  bank_pick_a: assert property (
    flag_we |=> active_bank == $past(flag_wdata[cbrf_pkg::FLAG_BANK_BIT]))
    else $error("bank select not taken from flag");

  ip_step_a: assert property (
    ip_adv && !ip_we && !sw_ip_we
    |=> instruction_pointer == 20'($past(instruction_pointer) + $past(ip_step)))
    else $error("pointer advance wrong");

  word_read_a: assert property (
    (dpa_size == cbrf_pkg::CBRF_SZ_WORD) && (dpa_sel == cbrf_pkg::IDX_DATA2)
    |=> dpa_data == {16'h0000, $past(act[2])})
    else $error("word read wrong");

  high_byte_a: assert property (
    (dpb_size == cbrf_pkg::CBRF_SZ_HI) && (dpb_sel == cbrf_pkg::IDX_DATA0)
    |=> dpb_data == {24'h00_0000, $past(act[0][15:8])})
    else $error("high byte read wrong");

  sw_ip_read_a: assert property (
    sw_re && (sw_addr == cbrf_pkg::OFS_IP)
    |=> sw_rdata == {12'h000, $past(instruction_pointer)})
    else $error("pointer read wrong");

  bank_swap_c:  cover property (!active_bank ##1 active_bank ##[1:200] !active_bank);
  pair_write_c: cover property (dpw_en && dpw_size == cbrf_pkg::CBRF_SZ_PAIR && !dpw_refused);
  byte_write_c: cover property (dpw_en && dpw_size == cbrf_pkg::CBRF_SZ_HI && !dpw_refused);
  refuse_c:     cover property (dpw_refused ##[1:4] sw_re && sw_addr == cbrf_pkg::OFS_STATUS);

endmodule

`default_nettype wire

// File: testbench/cbrf_dp_model.sv
// Datapath-side model: drives the read ports and the write port.
// Assumes the bench calls its tasks from one process, on the core clock.
`timescale 1ns/1ns
`default_nettype none

module cbrf_dp_model (
  input  wire logic            clk,
  output logic      [2:0]      rd_sel,
  output cbrf_pkg::cbrf_size_t rd_size,
  input  wire logic [31:0]     rd_a,
  input  wire logic [31:0]     rd_b,
  output logic                 wr_en,
  output logic      [2:0]      wr_sel,
  output cbrf_pkg::cbrf_size_t wr_size,
  output logic      [31:0]     wr_data,
  input  wire logic            refused
);
  initial begin
    rd_sel = 3'h0;
    rd_size = cbrf_pkg::CBRF_SZ_WORD;
    wr_en = 1'b0;
    wr_sel = 3'h0;
    wr_size = cbrf_pkg::CBRF_SZ_WORD;
    wr_data = 32'h0;
  end

  // One write cycle; refusal sampled while the request stands
  task automatic wr(input logic [2:0] s, input cbrf_pkg::cbrf_size_t z,
                    input logic [31:0] d, output logic rf);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_size <= z;
    wr_data <= d;
    #1 rf = refused;
    @(posedge clk);
    wr_en <= 1'b0;
    // Released data must not look valid
    wr_data <= ~d;
  endtask

  task automatic rd(input logic [2:0] s, input cbrf_pkg::cbrf_size_t z,
                    output logic [31:0] a, output logic [31:0] b);
    @(posedge clk);
    rd_sel <= s;
    rd_size <= z;
    @(posedge clk);
    #1 a = rd_a;
    b = rd_b;
  endtask
endmodule

`default_nettype wire

// File: testbench/test_cpu_banked_register_file.sv
// Self-checking bench for the banked register file against an array model.
// Assumes the package and the datapath model compile first.
`timescale 1ns/1ns
`default_nettype none

module test_cpu_banked_register_file;
  logic                 clk, rst_b, sw_we, sw_re, we, wref, flag_we, bank, ip_we, ip_adv, f, mb;
  logic [3:0]           sw_addr;
  logic [31:0]          sw_wdata, sw_rdata, ra, rb, wd, x, y;
  logic [2:0]           rs, ws, ip_step;
  cbrf_pkg::cbrf_size_t rz, wz;
  logic [15:0]          flag_wdata, ab0, ab1, fb;
  logic [19:0]          ip_wdata, ip, mip;
  logic [15:0]          m [2][7];
  integer               seed;
  int                   n_mismatch, num_checks, cyc;

  cbrf_regfile u_dut (.clk(clk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .dpa_sel(rs), .dpa_size(rz),
    .dpa_data(ra), .dpb_sel(rs), .dpb_size(rz), .dpb_data(rb), .dpw_en(we), .dpw_sel(ws),
    .dpw_size(wz), .dpw_data(wd), .dpw_refused(wref), .flag_we(flag_we),
    .flag_wdata(flag_wdata), .active_bank(bank), .ip_we(ip_we), .ip_wdata(ip_wdata),
    .ip_adv(ip_adv), .ip_step(ip_step), .instruction_pointer(ip), .addr_base_0(ab0),
    .addr_base_1(ab1), .frame_base(fb));
  cbrf_dp_model u_dp (.clk(clk), .rd_sel(rs), .rd_size(rz), .rd_a(ra), .rd_b(rb),
    .wr_en(we), .wr_sel(ws), .wr_size(wz), .wr_data(wd), .refused(wref));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Pair upper half: data pairs step by two, the address pair by one
  function automatic logic [2:0] hi_of(input logic [2:0] s);
    return (s == 3'h4) ? 3'h5 : s + 3'h2;
  endfunction

  function automatic void mwr(input logic [2:0] s, input cbrf_pkg::cbrf_size_t z,
                              input logic [31:0] d);
    case (z)
      cbrf_pkg::CBRF_SZ_LO:   m[mb][s][7:0] = d[7:0];
      cbrf_pkg::CBRF_SZ_HI:   m[mb][s][15:8] = d[7:0];
      cbrf_pkg::CBRF_SZ_WORD: m[mb][s] = d[15:0];
      default: begin
        m[mb][s] = d[15:0];
        m[mb][hi_of(s)] = d[31:16];
      end
    endcase
  endfunction

  function automatic logic [31:0] mrd(input logic [2:0] s, input cbrf_pkg::cbrf_size_t z);
    case (z)
      cbrf_pkg::CBRF_SZ_LO:   return {24'h0, m[mb][s][7:0]};
      cbrf_pkg::CBRF_SZ_HI:   return {24'h0, m[mb][s][15:8]};
      cbrf_pkg::CBRF_SZ_WORD: return {16'h0, m[mb][s]};
      default:                return {m[mb][hi_of(s)], m[mb][s]};
    endcase
  endfunction

  task automatic sw_op(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    @(posedge clk);
    sw_we <= w;
    sw_re <= !w;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_we <= 1'b0;
    sw_re <= 1'b0;
    #1 q = sw_rdata;
  endtask

  task automatic set_bank(input logic b);
    @(posedge clk);
    flag_we <= 1'b1;
    flag_wdata <= 16'($random(seed)) & 16'hFFEF | {11'h0, b, 4'h0};
    @(posedge clk);
    flag_we <= 1'b0;
    mb = b;
    #1 chk("bank", {31'h0, b}, {31'h0, bank});
  endtask

  task automatic ip_op(input logic ld, input logic [19:0] v, input logic [2:0] st);
    @(posedge clk);
    ip_we <= ld;
    ip_adv <= !ld;
    ip_wdata <= v;
    ip_step <= st;
    @(posedge clk);
    ip_we <= 1'b0;
    ip_adv <= 1'b0;
    mip = ld ? v : mip + 20'(st);
    #1 chk("ip", {12'h0, mip}, {12'h0, ip});
  endtask

  // Whole words into every banked register, read back on all paths
  task automatic fill_check(input logic b);
    // Old contents first, so a bank swap that lost data shows up
    for (int s = 0; s < 7; s++) begin
      sw_op(1'b0, 4'(s), 32'h0, y);
      chk("bank_keep", mrd(3'(s), cbrf_pkg::CBRF_SZ_WORD), y);
    end
    for (int s = 0; s < 7; s++) begin
      x = $random(seed);
      if (b) sw_op(1'b1, 4'(s), x, y);
      else u_dp.wr(3'(s), cbrf_pkg::CBRF_SZ_WORD, x, f);
      mwr(3'(s), cbrf_pkg::CBRF_SZ_WORD, x);
    end
    for (int s = 0; s < 7; s++) begin
      sw_op(1'b0, 4'(s), 32'h0, x);
      chk("sw_word", mrd(3'(s), cbrf_pkg::CBRF_SZ_WORD), x);
      u_dp.rd(3'(s), cbrf_pkg::CBRF_SZ_WORD, x, y);
      chk("dpa_word", mrd(3'(s), cbrf_pkg::CBRF_SZ_WORD), x);
      chk("dpb_word", mrd(3'(s), cbrf_pkg::CBRF_SZ_WORD), y);
    end
    chk("addr_base", {m[mb][5], m[mb][4]}, {ab1, ab0});
    chk("frame_base", {16'h0, m[mb][6]}, {16'h0, fb});
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    seed = 32'hac89;
    {n_mismatch, num_checks} = '0;
    {rst_b, sw_we, sw_re, flag_we, ip_we, ip_adv, mb} = '0;
    {sw_addr, sw_wdata, flag_wdata, ip_wdata, ip_step, mip} = '0;
    foreach (m[b, r]) m[b][r] = 16'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 11; a++) begin
      sw_op(1'b0, 4'(a), 32'h0, x);
      chk("reset_read", 32'h0, x);
    end
    $display("test reset done");
    fill_check(1'b0);
    for (int k = 0; k < 8; k++) begin
      x = $random(seed);
      u_dp.wr(3'(k / 2 % 2), cbrf_pkg::cbrf_size_t'(k % 2), x, f);
      mwr(3'(k / 2 % 2), cbrf_pkg::cbrf_size_t'(k % 2), x);
      chk("byte_refused", 32'h0, {31'h0, f});
      u_dp.rd(3'(k / 2 % 2), cbrf_pkg::CBRF_SZ_WORD, x, y);
      chk("byte_merge", mrd(3'(k / 2 % 2), cbrf_pkg::CBRF_SZ_WORD), x);
      u_dp.rd(3'(k / 2 % 2), cbrf_pkg::cbrf_size_t'(k % 2), x, y);
      chk("byte_read", mrd(3'(k / 2 % 2), cbrf_pkg::cbrf_size_t'(k % 2)), y);
    end
    u_dp.wr(3'h2, cbrf_pkg::CBRF_SZ_LO, 32'hFF, f);
    chk("bad_byte", 32'h1, {31'h0, f});
    u_dp.wr(3'h7, cbrf_pkg::CBRF_SZ_WORD, 32'h0, f);
    chk("bad_word", 32'h1, {31'h0, f});
    u_dp.wr(3'h2, cbrf_pkg::CBRF_SZ_PAIR, 32'h0, f);
    chk("bad_pair", 32'h1, {31'h0, f});
    sw_op(1'b0, 4'h9, 32'h0, x);
    chk("status", 32'h2, x);
    $display("test bytes done");
    for (int i = 0; i < 3; i++) begin
      x = $random(seed);
      u_dp.wr(3'((i == 2) ? 4 : i), cbrf_pkg::CBRF_SZ_PAIR, x, f);
      mwr(3'((i == 2) ? 4 : i), cbrf_pkg::CBRF_SZ_PAIR, x);
      u_dp.rd(3'((i == 2) ? 4 : i), cbrf_pkg::CBRF_SZ_PAIR, x, y);
      chk("pair", mrd(3'((i == 2) ? 4 : i), cbrf_pkg::CBRF_SZ_PAIR), x);
    end
    $display("test pairs done");
    set_bank(1'b1);
    sw_op(1'b0, 4'h8, 32'h0, x);
    chk("flag", 32'h10, x);
    fill_check(1'b1);
    // Software path into the flag word
    sw_op(1'b1, 4'h8, 32'($random(seed)) & 32'hFFFF_FFEF, y);
    mb = 1'b0;
    chk("bank_sw", 32'h0, {31'h0, bank});
    set_bank(1'b0);
    fill_check(1'b0);
    $display("test banks done");
    ip_op(1'b1, 20'($random(seed)), 3'h0);
    repeat (4) ip_op(1'b0, 20'h0, 3'($random(seed)));
    ip_op(1'b1, 20'hFFFFE, 3'h0);
    ip_op(1'b0, 20'h0, 3'h7);
    x = $random(seed);
    sw_op(1'b1, 4'h7, x, y);
    mip = x[19:0];
    chk("ip_sw_wr", {12'h0, mip}, {12'h0, ip});
    sw_op(1'b0, 4'h7, 32'h0, x);
    chk("ip_sw", {12'h0, mip}, x);
    $display("test pointer done");
    give_verdict();
  end
endmodule

`default_nettype wire
